// ===== hdl/ebl_pkg.sv
package ebl_pkg;

    // ****************************************
    // geometry and timing
    // ****************************************
    localparam int NUM_CHAN = 4;
    localparam logic [8:0] CLK_DIV = 9'h100; // system clocks per memory clock
    localparam logic [7:0] CLK_HALF = 8'h80; // high and low phase length
    localparam logic [7:0] DIV_LAST = 8'hFF;
    localparam logic [3:0] SETTLE_CYC = 4'h8; // lets synchronisers fill before sensing
    localparam logic [4:0] CMD_BITS = 5'h09; // start, opcode, six address bits
    localparam logic [4:0] FRAME_LAST = 5'h18; // command bits plus sixteen data bits, minus one
    localparam int WORD_W = 16;

    // ****************************************
    // memory command and word addresses
    // ****************************************
    localparam logic [2:0] READ_OPCODE = 3'h6; // start bit then read opcode
    localparam logic [5:0] VENDOR_ADDR = 6'h00;
    localparam logic [5:0] SUBVENDOR_ADDR = 6'h01;

    // fallback words when no memory answers; values arbitrary
    localparam logic [15:0] DEF_VENDOR_ID = 16'h0000;
    localparam logic [15:0] DEF_SUBVENDOR_ID = 16'h0000;

    // ****************************************
    // register bit positions
    // ****************************************
    localparam int FEATURE_AUTODIR_BIT = 5;
    localparam int MODEM_INFRARED_BIT = 6;

    // synchroniser lanes
    localparam int PIN_SEL = 0;
    localparam int PIN_RDATA = 1;
    localparam int PIN_DIR = 2;
    localparam int PIN_IR = 3;
    localparam logic [3:0] PIN_IDLE = 4'hD; // select, straps idle high; read data low

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [3:0] {
        LD_SENSE = 4'h1,
        LD_SHIFT = 4'h2,
        LD_GAP = 4'h4,
        LD_DONE = 4'h8
    } ebl_ld_e;

    typedef struct packed {
        logic serial_clock;
        logic select;
        logic write_data;
    } ebl_ctrl_s;

    typedef struct packed {
        logic [15:0] vendor;
        logic [15:0] subvendor;
    } ebl_ids_s;

endpackage

// ===== hdl/ebl_sync.sv
`timescale 1ns/100ps
module ebl_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous levels in, filtered levels out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] f1_q;
    logic [WIDTH-1:0] f2_q;
    logic [WIDTH-1:0] f3_q;

    // three-stage chain; only the second stage reads the first
    always_ff @(posedge clk) begin
        if (rst) begin
            f1_q <= INIT;
            f2_q <= INIT;
            f3_q <= INIT;
        end else begin
            f1_q <= din;
            f2_q <= f1_q;
            f3_q <= f2_q;
        end
    end

    // a lane moves only when stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_lane
            always_ff @(posedge clk) begin
                if (rst) begin
                    dout[i] <= INIT[i];
                end else if (f2_q[i] == f3_q[i]) begin
                    dout[i] <= f3_q[i];
                end
            end
        end
    endgenerate

endmodule

// ===== hdl/ebl_loader.sv
`timescale 1ns/100ps
module ebl_loader (
    // clock and resets
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic SOFT_RESET,
    // serial configuration memory pins
    output logic CFGMEM_SERIAL_CLOCK,
    input wire logic CFGMEM_SELECT_I,
    output logic CFGMEM_SELECT_O,
    output logic CFGMEM_SELECT_OE,
    output logic CFGMEM_WRITE_DATA,
    input wire logic CFGMEM_READ_DATA,
    // board straps
    input wire logic AUTO_DIRECTION_STRAP_N,
    input wire logic INFRARED_STRAP_N,
    // memory control register fields
    input wire ebl_pkg::ebl_ctrl_s CFGMEM_CTRL,
    output logic CFGMEM_CTRL_RDATA,
    // load status and identification words
    output logic LOAD_DONE,
    output logic CFGMEM_PRESENT,
    output ebl_pkg::ebl_ids_s CFG_IDS,
    // per-channel strap copies
    output logic [ebl_pkg::NUM_CHAN-1:0] FEATURE_AUTO_DIRECTION,
    output logic [ebl_pkg::NUM_CHAN-1:0] MODEM_INFRARED
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [3:0] pin_raw;
    logic [3:0] pin_s;

    assign pin_raw = {INFRARED_STRAP_N, AUTO_DIRECTION_STRAP_N, CFGMEM_READ_DATA,
                      CFGMEM_SELECT_I};

    ebl_sync #(.WIDTH(4), .INIT(ebl_pkg::PIN_IDLE)) ebl_sync_i (
        .clk(CLK_SYS),
        .rst(RESET),
        .din(pin_raw),
        .dout(pin_s)
    );

    // ****************************************
    // load sequencer
    // ****************************************
    ebl_pkg::ebl_ld_e ld_q;
    logic [3:0] settle_q;
    logic [7:0] div_q;
    logic [4:0] bit_q;
    logic word_q; // 0 vendor, 1 sub-vendor
    logic [8:0] cmd_q;
    logic [15:0] data_q;
    logic period_end;
    logic frame_end;

    assign period_end = (div_q == ebl_pkg::DIV_LAST);
    assign frame_end = period_end && (bit_q == ebl_pkg::FRAME_LAST);

    // state walk: sense, two framed reads when a memory is fitted, then hand over to software
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ld_q <= ebl_pkg::LD_SENSE;
        end else begin
            case (ld_q)
                ebl_pkg::LD_SENSE: begin
                    if (settle_q == ebl_pkg::SETTLE_CYC) begin
                        // pulled-up select means a memory is fitted
                        ld_q <= pin_s[ebl_pkg::PIN_SEL] ? ebl_pkg::LD_SHIFT
                                                        : ebl_pkg::LD_DONE;
                    end
                end
                ebl_pkg::LD_SHIFT: begin
                    if (frame_end) begin
                        ld_q <= ebl_pkg::LD_GAP;
                    end
                end
                ebl_pkg::LD_GAP: begin
                    if (period_end) begin
                        ld_q <= word_q ? ebl_pkg::LD_DONE : ebl_pkg::LD_SHIFT;
                    end
                end
                ebl_pkg::LD_DONE: ld_q <= ebl_pkg::LD_DONE;
                default: ld_q <= ebl_pkg::LD_SENSE;
            endcase
        end
    end

    // settle counter while the select line is released
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            settle_q <= '0;
        end else if (ld_q == ebl_pkg::LD_SENSE && settle_q != ebl_pkg::SETTLE_CYC) begin
            settle_q <= settle_q + 4'h1;
        end
    end

    // divide-by-256 phase counter, free only while a frame or gap runs
    always_ff @(posedge CLK_SYS) begin
        if (RESET || ld_q == ebl_pkg::LD_SENSE || ld_q == ebl_pkg::LD_DONE) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    // bit position and word index across the two frames
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            bit_q <= '0;
            word_q <= 1'b0;
        end else if (ld_q == ebl_pkg::LD_SHIFT && period_end) begin
            bit_q <= frame_end ? 5'h00 : bit_q + 5'h01;
        end else if (ld_q == ebl_pkg::LD_GAP && period_end) begin
            word_q <= 1'b1;
        end
    end

    // command shifter, reloaded for each word; sends msb first
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cmd_q <= '0;
        end else if (ld_q != ebl_pkg::LD_SHIFT) begin
            cmd_q <= {ebl_pkg::READ_OPCODE,
                      (ld_q == ebl_pkg::LD_GAP) ? ebl_pkg::SUBVENDOR_ADDR
                                                : ebl_pkg::VENDOR_ADDR};
        end else if (period_end) begin
            cmd_q <= {cmd_q[7:0], 1'b0};
        end
    end

    // read data taken at the end of each high phase, once the command is out
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            data_q <= '0;
        end else if (ld_q == ebl_pkg::LD_SHIFT && period_end && bit_q >= ebl_pkg::CMD_BITS) begin
            data_q <= {data_q[14:0], pin_s[ebl_pkg::PIN_RDATA]};
        end
    end

    // identification words; defaults stand when no memory was sensed
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            CFG_IDS <= {ebl_pkg::DEF_VENDOR_ID, ebl_pkg::DEF_SUBVENDOR_ID};
        end else if (ld_q == ebl_pkg::LD_GAP && div_q == '0) begin
            if (word_q) begin
                CFG_IDS.subvendor <= data_q;
            end else begin
                CFG_IDS.vendor <= data_q;
            end
        end
    end

    // presence and completion flags
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            CFGMEM_PRESENT <= 1'b0;
            LOAD_DONE <= 1'b0;
        end else begin
            if (ld_q == ebl_pkg::LD_SENSE && settle_q == ebl_pkg::SETTLE_CYC) begin
                CFGMEM_PRESENT <= pin_s[ebl_pkg::PIN_SEL];
            end
            LOAD_DONE <= (ld_q == ebl_pkg::LD_DONE);
        end
    end

    // ****************************************
    // memory pin drivers
    // ****************************************
    // sequencer owns the pins until done, so writes cannot collide with a frame
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            CFGMEM_SERIAL_CLOCK <= 1'b0;
            CFGMEM_SELECT_O <= 1'b0;
            CFGMEM_SELECT_OE <= 1'b0;
            CFGMEM_WRITE_DATA <= 1'b0;
        end else begin
            case (ld_q)
                ebl_pkg::LD_SHIFT: begin
                    CFGMEM_SERIAL_CLOCK <= (div_q >= ebl_pkg::CLK_HALF);
                    CFGMEM_SELECT_O <= 1'b1;
                    CFGMEM_SELECT_OE <= 1'b1;
                    CFGMEM_WRITE_DATA <= cmd_q[8];
                end
                ebl_pkg::LD_DONE: begin
                    CFGMEM_SERIAL_CLOCK <= CFGMEM_CTRL.serial_clock;
                    CFGMEM_SELECT_O <= CFGMEM_CTRL.select;
                    CFGMEM_SELECT_OE <= 1'b1;
                    CFGMEM_WRITE_DATA <= CFGMEM_CTRL.write_data;
                end
                default: begin // sensing: select released; gap: deselected; clock low in both
                    CFGMEM_SERIAL_CLOCK <= 1'b0;
                    CFGMEM_SELECT_O <= 1'b0;
                    CFGMEM_SELECT_OE <= (ld_q != ebl_pkg::LD_SENSE);
                    CFGMEM_WRITE_DATA <= 1'b0;
                end
            endcase
        end
    end

    // read-data level returned to software
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            CFGMEM_CTRL_RDATA <= 1'b0;
        end else begin
            CFGMEM_CTRL_RDATA <= pin_s[ebl_pkg::PIN_RDATA];
        end
    end

    // ****************************************
    // strap capture, one copy per channel
    // ****************************************
    logic strap_take;

    // taken at the end of sensing and again on soft reset
    assign strap_take = SOFT_RESET ||
                        (ld_q == ebl_pkg::LD_SENSE && settle_q == ebl_pkg::SETTLE_CYC);

    // register bit is an enable, so a low strap reads back as one
    genvar ch;
    generate
        for (ch = 0; ch < ebl_pkg::NUM_CHAN; ch++) begin : g_chan
            always_ff @(posedge CLK_SYS) begin
                if (RESET) begin
                    FEATURE_AUTO_DIRECTION[ch] <= 1'b0;
                    MODEM_INFRARED[ch] <= 1'b0;
                end else if (strap_take) begin
                    FEATURE_AUTO_DIRECTION[ch] <= !pin_s[ebl_pkg::PIN_DIR];
                    MODEM_INFRARED[ch] <= !pin_s[ebl_pkg::PIN_IR];
                end
            end
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    logic [7:0] run_q; // cycles the memory clock has held its level
    logic clk_prev_q;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            run_q <= '0;
            clk_prev_q <= 1'b0;
        end else begin
            clk_prev_q <= CFGMEM_SERIAL_CLOCK;
            if (CFGMEM_SERIAL_CLOCK != clk_prev_q) begin
                run_q <= 8'h01;
            end else if (run_q != 8'hFF) begin
                run_q <= run_q + 8'h01;
            end
        end
    end

    sequence s_in_load;
        ld_q == ebl_pkg::LD_SHIFT && $past(ld_q) == ebl_pkg::LD_SHIFT;
    endsequence

    sequence s_in_done;
        ld_q == ebl_pkg::LD_DONE && $past(ld_q) == ebl_pkg::LD_DONE;
    endsequence

    a_clock_high_half: assert property (
        s_in_load ##0 $fell(CFGMEM_SERIAL_CLOCK) |-> run_q == ebl_pkg::CLK_HALF)
        else $error("memory clock high phase is not 128 cycles");
    a_manual_clock: assert property (s_in_done |->
        CFGMEM_SERIAL_CLOCK == $past(CFGMEM_CTRL.serial_clock))
        else $error("memory clock does not follow control bit");
    a_manual_select: assert property (s_in_done |->
        CFGMEM_SELECT_O == $past(CFGMEM_CTRL.select) && CFGMEM_SELECT_OE)
        else $error("select does not follow control bit");
    a_sense_released: assert property (
        ld_q == ebl_pkg::LD_SENSE |=> !CFGMEM_SELECT_OE)
        else $error("select driven while sensing presence");
    a_manual_wdata: assert property (s_in_done |->
        CFGMEM_WRITE_DATA == $past(CFGMEM_CTRL.write_data))
        else $error("write data does not follow control bit");
    a_rdata_readback: assert property (
        $stable(CFGMEM_READ_DATA) [*7] |-> CFGMEM_CTRL_RDATA == CFGMEM_READ_DATA)
        else $error("read data level not returned");
    a_dir_strap_copy: assert property (
        $stable(AUTO_DIRECTION_STRAP_N) [*6] ##0 SOFT_RESET |=>
        FEATURE_AUTO_DIRECTION[0] == !$past(AUTO_DIRECTION_STRAP_N))
        else $error("direction strap not copied");
    a_dir_all_chan: assert property (
        strap_take && !pin_s[ebl_pkg::PIN_DIR] |=> FEATURE_AUTO_DIRECTION == '1)
        else $error("low direction strap did not enable every channel");
    a_ir_strap_copy: assert property (
        $stable(INFRARED_STRAP_N) [*6] ##0 SOFT_RESET |=>
        MODEM_INFRARED == {ebl_pkg::NUM_CHAN{!$past(INFRARED_STRAP_N)}})
        else $error("infrared strap not copied");
    a_load_owns_pins: assert property (
        s_in_load |-> CFGMEM_SELECT_O && CFGMEM_SELECT_OE && !LOAD_DONE)
        else $error("manual control leaked into the load");

endmodule

// ===== tb/ebl_mem_model.sv
`timescale 1ns/100ps
module ebl_mem_model #(
    parameter logic [15:0] WORD0 = 16'hA5C3,
    parameter logic [15:0] WORD1 = 16'h3C5A
) (
    // memory pins
    input wire logic sck,
    input wire logic sel,
    input wire logic din,
    // bench control of the read line
    input wire logic hold_en,
    input wire logic hold_val,
    output logic dout
);
    logic [8:0] cmd_q;
    logic [15:0] word_q;
    logic out_q = 1'b0;
    int cnt_q = 0;

    // ****************************************
    // command shifts in on rising clock edges
    // ****************************************
    always @(posedge sck or negedge sel) begin
        if (!sel) begin
            cnt_q <= 0;
        end else begin
            cmd_q <= {cmd_q[7:0], din};
            cnt_q <= cnt_q + 1;
        end
    end

    // data moves on falling edges so it is steady through the high phase
    always @(negedge sck) begin
        if (sel && cnt_q == 9) begin
            // a bad opcode gives all ones, which no expected word matches
            word_q <= (cmd_q[8:6] != 3'h6) ? 16'hFFFF :
                      (cmd_q[5:0] == 6'h01) ? {WORD1[14:0], 1'b0} : {WORD0[14:0], 1'b0};
            out_q <= (cmd_q[8:6] != 3'h6) ? 1'b1 :
                     (cmd_q[5:0] == 6'h01) ? WORD1[15] : WORD0[15];
        end else if (sel && cnt_q > 9) begin
            out_q <= word_q[15];
            word_q <= {word_q[14:0], 1'b0};
        end
    end

    // deselected: no pull on the line, so show the inverse, never a stale value
    assign dout = hold_en ? hold_val : (sel ? out_q : ~out_q);
endmodule

// ===== tb/eeprom_boot_and_strap_loader_bench.sv
`timescale 1ns/100ps
module eeprom_boot_and_strap_loader_bench;
    localparam logic [15:0] W0 = 16'hA5C3;
    localparam logic [15:0] W1 = 16'h3C5A;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic soft_reset = 1'b0;
    logic fitted = 1'b1;
    logic dir_n = 1'b1;
    logic ir_n = 1'b1;
    logic hold_en = 1'b0;
    logic hold_val = 1'b0;
    ebl_pkg::ebl_ctrl_s ctrl = '0;
    logic sck, sel_o, sel_oe, wdata, rdata, ctrl_rdata, done, present, sel_wire;
    ebl_pkg::ebl_ids_s ids;
    logic [3:0] feat, modem;
    int n_fail = 0;
    int comparisons = 0;
    int gap_seen;

    // ****************************************
    // clock, pin wiring and instances
    // ****************************************
    always #25 clk = ~clk;
    // select pin: pulled up only when a memory is fitted
    assign sel_wire = sel_oe ? sel_o : fitted;

    ebl_loader ebl_loader_i (
        .CLK_SYS(clk), .RESET(reset), .SOFT_RESET(soft_reset),
        .CFGMEM_SERIAL_CLOCK(sck), .CFGMEM_SELECT_I(sel_wire),
        .CFGMEM_SELECT_O(sel_o), .CFGMEM_SELECT_OE(sel_oe),
        .CFGMEM_WRITE_DATA(wdata), .CFGMEM_READ_DATA(rdata),
        .AUTO_DIRECTION_STRAP_N(dir_n), .INFRARED_STRAP_N(ir_n),
        .CFGMEM_CTRL(ctrl), .CFGMEM_CTRL_RDATA(ctrl_rdata),
        .LOAD_DONE(done), .CFGMEM_PRESENT(present), .CFG_IDS(ids),
        .FEATURE_AUTO_DIRECTION(feat), .MODEM_INFRARED(modem)
    );

    ebl_mem_model #(.WORD0(W0), .WORD1(W1)) ebl_mem_model_i (
        .sck(sck), .sel(sel_wire & fitted), .din(wdata),
        .hold_en(hold_en), .hold_val(hold_val), .dout(rdata)
    );

    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    // reset held six cycles, then the sense window plus margin
    task automatic do_reset();
        reset <= 1'b1;
        cycles(6);
        reset <= 1'b0;
        cycles(12);
    endtask

    // wait for the load end, counting gap cycles with select driven low
    task automatic wait_done(input int limit);
        int k;
        gap_seen = 0;
        for (k = 0; k < limit && done !== 1'b1; k++) begin
            @(posedge clk);
            if (sel_oe === 1'b1 && sel_o === 1'b0) gap_seen++;
        end
        chk("load done", 1, done);
    endtask

    task automatic pulse_soft(input int n);
        soft_reset <= 1'b1;
        cycles(n);
        soft_reset <= 1'b0;
        cycles(3);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ****************************************
    // watchdog: one load of about 13.3k cycles with memory plus short tests
    // ****************************************
    initial begin
        cycles(60000);
        n_fail++;
        $display("MISMATCH watchdog expected end seen hang");
        conclude();
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        int i, t;
        // boot with memory, ctrl held all ones to show it is ignored
        dir_n <= 1'b0;
        ir_n <= 1'b1;
        ctrl <= 3'h7;
        do_reset();
        chk("present", 1, present);
        chk("feature copies", 4'hF, feat);
        chk("modem copies", 4'h0, modem);
        // clock period in a frame, rising edge to rising edge
        t = 0;
        while (sck !== 1'b1 && t < 2000) begin
            @(posedge clk);
            t++;
        end
        t = 0;
        while (sck !== 1'b0 && t < 2000) begin
            @(posedge clk);
            t++;
        end
        while (sck !== 1'b1 && t < 2000) begin
            @(posedge clk);
            t++;
        end
        chk("clock period", 256, t);
        wait_done(20000);
        chk("gap select low", 1, gap_seen > 0);
        chk("ids", {W0, W1}, ids);
        $display("test boot_with_memory done");

        // manual drive of the memory pins after the load
        for (i = 0; i < 8; i++) begin
            ctrl <= i[2:0];
            cycles(3);
            chk("manual pins", i, {sck, sel_o, wdata});
        end
        hold_en <= 1'b1;
        for (i = 0; i < 2; i++) begin
            hold_val <= i[0];
            cycles(8);
            chk("read data", i, ctrl_rdata);
        end
        hold_en <= 1'b0;
        $display("test manual_control done");

        // soft reset re-samples straps only
        dir_n <= 1'b1;
        ir_n <= 1'b0;
        cycles(6);
        pulse_soft(1);
        chk("soft feature", 4'h0, feat);
        chk("soft modem", 4'hF, modem);
        dir_n <= 1'b0;
        ir_n <= 1'b1;
        cycles(6);
        pulse_soft(2);
        chk("soft feature again", 4'hF, feat);
        chk("soft modem again", 4'h0, modem);
        chk("ids kept", {W0, W1}, ids);
        chk("done kept", 1, done);
        $display("test soft_reset done");

        // second hardware reset with no memory fitted
        fitted <= 1'b0;
        dir_n <= 1'b1;
        ir_n <= 1'b0;
        ctrl <= 3'h0;
        do_reset();
        wait_done(40);
        chk("absent", 0, present);
        chk("default ids", {ebl_pkg::DEF_VENDOR_ID, ebl_pkg::DEF_SUBVENDOR_ID}, ids);
        chk("feature no mem", 4'h0, feat);
        chk("modem no mem", 4'hF, modem);
        $display("test boot_without_memory done");
        conclude();
    end
endmodule
